// ==== hdl/ssp_defines.vh ====
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// Core clock 20 MHz, period in ns
`define SSP_CLK_NS 50
// Serial clock watchdog, about two seconds
`define SSP_SCL_WD_MS 2000
`define SSP_SCL_WD_CYC (`SSP_SCL_WD_MS * 1000000 / `SSP_CLK_NS)
// Internal oscillator absence limit
`define SSP_OSC_WD_MS 20
`define SSP_OSC_WD_CYC (`SSP_OSC_WD_MS * 1000000 / `SSP_CLK_NS)
// Address byte fields
`define SSP_ADDR_HI 5
`define SSP_ADDR_LO 1
`define SSP_RW_BIT 0
// Select byte fields
`define SSP_REG_HI 6
`define SSP_REG_LO 3
`define SSP_PORT_HI 1
`define SSP_PORT_LO 0
// Register codes
`define SSP_REG_COMMON_RD 4'h0
`define SSP_REG_COMMON_CTL 4'h1
`define SSP_REG_COMMON_TEST 4'hf
// Software reset bit of the common control register
`define SSP_SWRST_BIT 7
`define SSP_SEL_RESET 8'h00
`define SSP_NPORTS 4
`endif

// ==== hdl/ssp_serial_port.v ====
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.vh"
module ssp_serial_port
#(
	parameter SCL_WD_CYC = `SSP_SCL_WD_CYC,
	parameter OSC_WD_CYC = `SSP_OSC_WD_CYC
)
(
	input wire core_clk,
	input wire reset_n,
	input wire power_on_reset_pin_n,
	input wire supplies_ok,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	input wire [4:0] address_strap_pins,
	input wire watchdog_disable_pin,
	input wire host_managed_mode,
	input wire autonomous_mode,
	input wire osc_tick,
	input wire [7:0] read_data,
	output reg [3:0] reg_code,
	output reg [1:0] port_num,
	output reg read_strobe,
	output reg [7:0] write_data,
	output reg write_strobe,
	output reg [3:0] port_write_mask,
	output reg ports_disabled,
	output reg interrupt_out_n
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_SEL = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_IGNORE = 3'h5;

	wire [2:0] sync_w;
	wire scl_s;
	wire sda_s;
	wire por_s_n;
	wire rst_n;
	reg scl_prev_q;
	reg sda_prev_q;
	reg [2:0] state_q;
	reg [3:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg ack_phase_q;
	reg [7:0] tx_q;
	reg tx_phase_q;
	reg [25:0] scl_wd_q;
	reg [18:0] osc_wd_q;
	reg scl_trip_q;
	reg osc_trip_q;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;
	wire addr_match;
	wire sw_reset;
	wire wd_off;
	wire [2:0] mode_w;
	wire host_s;
	wire auto_s;

	ssp_sync u_sync
	(
		.clk(core_clk),
		.reset_n(reset_n),
		.async_in({power_on_reset_pin_n, sda_in, scl_in}),
		.sync_out(sync_w)
	);
	assign scl_s = sync_w[0];
	assign sda_s = sync_w[1];
	assign por_s_n = sync_w[2];

	// Mode pins may be moved by a host at any time, so they are synchronised too
	ssp_sync u_mode_sync
	(
		.clk(core_clk),
		.reset_n(reset_n),
		.async_in({watchdog_disable_pin, host_managed_mode, autonomous_mode}),
		.sync_out(mode_w)
	);
	assign host_s = mode_w[1];
	assign auto_s = mode_w[0];

	// Held in reset until the power-on pin and supplies agree
	wire hold_rst;
	reg supplies_q;
	reg supplies_s_q;
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			supplies_q <= 1'b0;
			supplies_s_q <= 1'b0;
		end
		else
		begin
			supplies_q <= supplies_ok;
			supplies_s_q <= supplies_q;
		end
	end
	assign hold_rst = !por_s_n || !supplies_s_q;
	assign rst_n = reset_n;

	assign scl_rise = scl_s && !scl_prev_q;
	assign scl_fall = !scl_s && scl_prev_q;
	assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
	assign addr_match = shift_q[`SSP_ADDR_HI:`SSP_ADDR_LO] == address_strap_pins;
	assign sw_reset = write_strobe && reg_code == `SSP_REG_COMMON_CTL
		&& write_data[`SSP_SWRST_BIT];
	assign wd_off = mode_w[2];

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// Serial protocol engine; only samples the clock, never drives it
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ack_phase_q <= 1'b0;
			tx_q <= 8'h00;
			tx_phase_q <= 1'b0;
			sda_out <= 1'b1;
			reg_code <= 4'h0;
			port_num <= 2'h0;
			read_strobe <= 1'b0;
			write_data <= 8'h00;
			write_strobe <= 1'b0;
			port_write_mask <= 4'h0;
		end
		else if (hold_rst)
		begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			ack_phase_q <= 1'b0;
			tx_phase_q <= 1'b0;
			sda_out <= 1'b1;
			reg_code <= 4'h0;
			port_num <= 2'h0;
			read_strobe <= 1'b0;
			write_strobe <= 1'b0;
			port_write_mask <= 4'h0;
		end
		else
		begin
			read_strobe <= 1'b0;
			write_strobe <= 1'b0;
			if (start_det)
			begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				ack_phase_q <= 1'b0;
				tx_phase_q <= 1'b0;
				sda_out <= 1'b1;
			end
			else if (stop_det)
			begin
				state_q <= ST_IDLE;
				ack_phase_q <= 1'b0;
				tx_phase_q <= 1'b0;
				sda_out <= 1'b1;
			end
			else if (scl_rise && !ack_phase_q && !tx_phase_q
				&& state_q != ST_IDLE && state_q != ST_IGNORE)
			begin
				shift_q <= {shift_q[6:0], sda_s};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
			else if (scl_fall)
			begin
				if (ack_phase_q)
				begin
					// Ack held through the ninth high phase, then released here, or replaced by the first read data bit
					ack_phase_q <= 1'b0;
					sda_out <= 1'b1;
					if (state_q == ST_RDATA)
					begin
						tx_phase_q <= 1'b1;
						sda_out <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
						bit_cnt_q <= 4'h1;
					end
				end
				else if (tx_phase_q)
				begin
					if (bit_cnt_q == 4'h8)
					begin
						// Master's not-acknowledge clock; output stays released
						tx_phase_q <= 1'b0;
						sda_out <= 1'b1;
						state_q <= ST_IGNORE;
					end
					else
					begin
						sda_out <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
				else if (bit_cnt_q == 4'h8)
				begin
					bit_cnt_q <= 4'h0;
					case (state_q)
					ST_ADDR:
					begin
						if (addr_match)
						begin
							ack_phase_q <= 1'b1;
							sda_out <= 1'b0;
							if (shift_q[`SSP_RW_BIT])
							begin
								state_q <= ST_RDATA;
								tx_q <= read_data;
								read_strobe <= 1'b1;
							end
							else
								state_q <= ST_SEL;
						end
						else
							state_q <= ST_IGNORE;
					end
					ST_SEL:
					begin
						reg_code <= shift_q[`SSP_REG_HI:`SSP_REG_LO];
						port_num <= shift_q[`SSP_PORT_HI:`SSP_PORT_LO];
						ack_phase_q <= 1'b1;
						sda_out <= 1'b0;
						state_q <= ST_WDATA;
					end
					ST_WDATA:
					begin
						write_data <= shift_q;
						write_strobe <= 1'b1;
						if (reg_code == `SSP_REG_COMMON_CTL || reg_code == `SSP_REG_COMMON_TEST)
							port_write_mask <= 4'hf;
						else
							port_write_mask <= 4'h1 << port_num;
						ack_phase_q <= 1'b1;
						sda_out <= 1'b0;
						state_q <= ST_IGNORE;
					end
					default:
						state_q <= ST_IGNORE;
					endcase
				end
			end
		end
	end

	// Watchdogs; serial clock one only in host-managed mode
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_wd_q <= 26'h0;
			osc_wd_q <= 19'h0;
			scl_trip_q <= 1'b0;
			osc_trip_q <= 1'b0;
		end
		else if (hold_rst)
		begin
			scl_wd_q <= 26'h0;
			osc_wd_q <= 19'h0;
			scl_trip_q <= 1'b0;
			osc_trip_q <= 1'b0;
		end
		else
		begin
			if (scl_rise || scl_fall || sw_reset || !host_s || auto_s)
				scl_wd_q <= 26'h0;
			else if (scl_wd_q != SCL_WD_CYC[25:0])
				scl_wd_q <= scl_wd_q + 26'h1;
			// A trip in the same cycle as a software reset still sticks
			if (scl_wd_q == SCL_WD_CYC[25:0] && host_s && !wd_off)
				scl_trip_q <= 1'b1;
			else if (sw_reset)
				scl_trip_q <= 1'b0;
			if (osc_tick || sw_reset)
				osc_wd_q <= 19'h0;
			else if (osc_wd_q != OSC_WD_CYC[18:0])
				osc_wd_q <= osc_wd_q + 19'h1;
			// Clears once the oscillator returns
			osc_trip_q <= osc_wd_q == OSC_WD_CYC[18:0] && !wd_off;
		end
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ports_disabled <= 1'b1;
			interrupt_out_n <= 1'b1;
		end
		else
		begin
			// Disable pin masks a standing trip too, so no stray shutdown on mode change
			ports_disabled <= hold_rst
				|| ((scl_trip_q || osc_trip_q) && !wd_off);
			interrupt_out_n <= !(host_s && !auto_s && !wd_off
				&& (scl_trip_q || osc_trip_q));
		end
	end
endmodule // ssp_serial_port
`default_nettype wire

// ==== hdl/ssp_sync.v ====
`timescale 1ns/1ns
`default_nettype none
module ssp_sync
(
	input wire clk,
	input wire reset_n,
	input wire [2:0] async_in,
	output reg [2:0] sync_out
);
	reg [2:0] meta_q;
	// Idle-high reset value keeps a released bus from looking like an edge
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= 3'h7;
			sync_out <= 3'h7;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // ssp_sync
`default_nettype wire

// ==== tb/ssp_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssp_chk
#(
	parameter SCL_WD_CYC = 200,
	parameter OSC_WD_CYC = 50
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic power_on_reset_pin_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic watchdog_disable_pin,
	input wire logic host_managed_mode,
	input wire logic autonomous_mode,
	input wire logic osc_tick,
	input wire logic [3:0] reg_code,
	input wire logic [1:0] port_num,
	input wire logic write_strobe,
	input wire logic [3:0] port_write_mask,
	input wire logic ports_disabled,
	input wire logic interrupt_out_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire [4:0] cfg_d = {power_on_reset_pin_n, scl_in, watchdog_disable_pin, host_managed_mode,
		autonomous_mode};
	logic [4:0] cfg_q;
	int scl_idle_q, osc_idle_q;
	// Pin changes restart the clock idle count, and power-on or disable pin changes the oscillator one, so a stale count never blames the design
	always @(posedge core_clk or negedge reset_n)
		if (!reset_n)
		begin
			cfg_q <= 5'h0;
			scl_idle_q <= 0;
			osc_idle_q <= 0;
		end
		else
		begin
			cfg_q <= cfg_d;
			scl_idle_q <= (cfg_d != cfg_q) ? 0 : scl_idle_q + 1;
			osc_idle_q <= (osc_tick || cfg_d[4] != cfg_q[4] || cfg_d[2] != cfg_q[2])
				? 0 : osc_idle_q + 1;
		end
	por_hold_a: assert property (!power_on_reset_pin_n [*4] |-> ports_disabled)
		else $error("ports enabled while power-on reset held");
	sda_edge_a: assert property (sda_out != $past(sda_out) |-> !scl_in)
		else $error("data output changed while clock high");
	wr_ack_a: assert property (write_strobe |-> ##[0:2] !sda_out)
		else $error("data byte stored without acknowledge");
	mask_common_a: assert property (write_strobe && (reg_code == 4'h1 || reg_code == 4'hf)
		|-> port_write_mask == 4'hf)
		else $error("common write not applied to all ports");
	mask_port_a: assert property (write_strobe && reg_code != 4'h1 && reg_code != 4'hf
		|-> port_write_mask == (4'h1 << port_num))
		else $error("port write mask wrong");
	irq_cause_a: assert property ($fell(interrupt_out_n)
		|-> host_managed_mode && !watchdog_disable_pin)
		else $error("interrupt outside host-managed watchdog");
	scl_wd_a: assert property (scl_idle_q > SCL_WD_CYC + 8 && host_managed_mode
		&& !autonomous_mode && !watchdog_disable_pin |-> ports_disabled)
		else $error("clock watchdog did not disable ports");
	osc_wd_a: assert property (osc_idle_q > OSC_WD_CYC + 8 && !watchdog_disable_pin
		|-> ports_disabled)
		else $error("oscillator watchdog did not disable ports");
endmodule // ssp_chk
bind ssp_serial_port ssp_chk #(.SCL_WD_CYC(SCL_WD_CYC), .OSC_WD_CYC(OSC_WD_CYC)) chk_u (
	.core_clk, .reset_n, .power_on_reset_pin_n, .scl_in, .sda_out, .watchdog_disable_pin,
	.host_managed_mode, .autonomous_mode, .osc_tick, .reg_code, .port_num, .write_strobe,
	.port_write_mask, .ports_disabled, .interrupt_out_n);
`default_nettype wire

// ==== tb/ssp_i2c_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssp_i2c_master
(
	input wire logic core_clk,
	input wire logic sda_out,
	output logic scl,
	output logic sda
);
	// Clock stands high between frames, data released to its pull-up level
	initial {scl, sda} = 2'b11;
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic start();
		wt(8);
		sda = 1'b0;
		wt(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		wt(4);
		sda = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda = 1'b1;
		wt(8);
	endtask
	// Data moves mid-low so the slave never sees it change with the clock edge
	task automatic xfer(input logic [7:0] d, output logic [8:0] r);
		for (int i = 0; i < 9; i++)
		begin
			wt(4);
			sda = (i < 8) ? d[7 - i] : 1'b1;
			wt(8);
			scl = 1'b1;
			wt(8);
			r = {r[7:0], sda_out};
			scl = 1'b0;
		end
	endtask
endmodule // ssp_i2c_master
`default_nettype wire

// ==== tb/test_serial_slave_port_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_serial_slave_port_watchdog;
	logic core_clk, reset_n, por_n, sup_ok, wdd, hmm, am, osc_run;
	logic osc_tick, scl, sda, sda_out, read_strobe, write_strobe, ports_disabled, irq_n;
	logic [7:0] read_data, write_data, wd_q;
	logic [4:0] strap;
	logic [3:0] reg_code, mask, mask_q;
	logic [1:0] port_num;
	logic [8:0] r;
	int fails = 0, checks_done = 0, cyc = 0, wr_n = 0;
	ssp_i2c_master m_u (.core_clk, .sda_out, .scl, .sda);
	ssp_serial_port #(.SCL_WD_CYC(200), .OSC_WD_CYC(50)) dut_u (.core_clk, .reset_n,
		.power_on_reset_pin_n(por_n), .supplies_ok(sup_ok), .scl_in(scl), .sda_in(sda), .sda_out,
		.address_strap_pins(strap), .watchdog_disable_pin(wdd), .host_managed_mode(hmm),
		.autonomous_mode(am), .osc_tick, .read_data, .reg_code, .port_num, .read_strobe,
		.write_data, .write_strobe, .port_write_mask(mask), .ports_disabled,
		.interrupt_out_n(irq_n));
	always #25 core_clk = ~core_clk;
	always @(negedge core_clk)
	begin
		osc_tick <= osc_run & cyc[0];
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			end_of_test();
		end
	end
	always @(posedge core_clk)
		if (write_strobe === 1'b1)
		begin
			wd_q <= write_data;
			mask_q <= mask;
			wr_n <= wr_n + 1;
		end
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d,
		input logic [8:0] e);
		m_u.start();
		m_u.xfer(a, r);
		chk(r, e);
		m_u.xfer(s, r);
		chk(r, e);
		m_u.xfer(d, r);
		chk(r, e);
		m_u.stop();
	endtask
	task automatic rd(input logic [7:0] s, input logic [7:0] d);
		read_data = d;
		m_u.start();
		m_u.xfer({2'b00, strap, 1'b0}, r);
		chk(r, 9'h1fe);
		m_u.xfer(s, r);
		chk(r, 9'h1fe);
		m_u.stop();
		m_u.start();
		m_u.xfer({2'b00, strap, 1'b1}, r);
		chk(r, 9'h1fe);
		m_u.xfer(8'hff, r);
		chk(r, {d, 1'b1});
		m_u.stop();
	endtask
	task automatic end_of_test();
		$display("fails %0d checks_done %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		por_n = 1'b0;
		sup_ok = 1'b1;
		wdd = 1'b0;
		hmm = 1'b1;
		am = 1'b0;
		osc_run = 1'b1;
		read_data = 8'h00;
		strap = 5'h0b;
		m_u.wt(2);
		reset_n = 1;
		m_u.wt(6);
		chk({8'h0, ports_disabled}, 9'h001);
		por_n = 1;
		m_u.wt(8);
		chk({6'h0, ports_disabled, irq_n, sda_out}, 9'h003);
		for (int i = 0; i < 16; i++)
		begin
			wr({i[1:0], strap, 1'b0}, {1'b0, i[3:0], 1'b0, i[1:0]}, i[7:0], 9'h1fe);
			chk({1'b0, wd_q}, i[8:0]);
			chk({1'b0, reg_code, mask_q},
				{1'b0, i[3:0], (i == 1 || i == 15) ? 4'hf : 4'h1 << i[1:0]});
			chk({7'h0, port_num}, {7'h0, i[1:0]});
		end
		for (int j = 0; j < 5; j++)
			wr({2'b00, strap ^ (5'h01 << j), 1'b0}, 8'h18, 8'h55, 9'h1ff);
		chk(wr_n[8:0], 9'h010);
		strap = 5'h14;
		wr({2'b10, strap, 1'b0}, 8'h1a, 8'h3c, 9'h1fe);
		chk({1'b0, wd_q}, 9'h03c);
		chk({1'b0, reg_code, mask_q}, 9'h034);
		rd(8'h2b, 8'h96);
		chk({3'h0, reg_code, port_num}, 9'h017);
		m_u.wt(260);
		chk({7'h0, ports_disabled, irq_n}, 9'h002);
		wr({2'b00, strap, 1'b0}, 8'h08, 8'h80, 9'h1fe);
		m_u.wt(8);
		chk({8'h0, ports_disabled}, 9'h000);
		m_u.wt(260);
		chk({7'h0, ports_disabled, irq_n}, 9'h002);
		por_n = 0;
		m_u.wt(8);
		chk({7'h0, ports_disabled, irq_n}, 9'h003);
		por_n = 1;
		m_u.wt(8);
		chk({8'h0, ports_disabled}, 9'h000);
		sup_ok = 0;
		m_u.wt(8);
		chk({8'h0, ports_disabled}, 9'h001);
		sup_ok = 1;
		m_u.wt(8);
		chk({8'h0, ports_disabled}, 9'h000);
		{hmm, am} = 2'b01;
		m_u.wt(300);
		chk({8'h0, ports_disabled}, 9'h000);
		osc_run = 0;
		m_u.wt(80);
		chk({7'h0, ports_disabled, irq_n}, 9'h003);
		osc_run = 1;
		{wdd, hmm, am} = 3'b110;
		m_u.wt(8);
		osc_run = 0;
		m_u.wt(300);
		chk({7'h0, ports_disabled, irq_n}, 9'h001);
		end_of_test();
	end
endmodule // test_serial_slave_port_watchdog
`default_nettype wire
